// ===== msra_dev.sv
`timescale 1ns/1ps
`include "msra_regs.svh"
module msra_dev #(
    parameter int PRE_BITS = `MSRA_PRE_BITS
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // management link
    msra_if.dev link,
    // register access side
    output logic acc_rd_o,
    output logic acc_wr_o,
    output logic acc_cfg_o,
    output logic [4:0] acc_phy_o,
    output logic [7:0] acc_addr_o,
    output logic [15:0] acc_wdata_o,
    input wire logic [15:0] acc_rdata_i
);
    import msra_pkg::*;

    localparam logic [5:0] PRE_CNT = 6'(PRE_BITS);
    localparam logic [3:0] HDR_LAST = 4'(`MSRA_HDR_BITS - 1);
    localparam logic [3:0] DATA_LAST = 4'(`MSRA_DATA_BITS - 1);

    logic [1:0] mdc_s_r;
    logic [1:0] mdio_s_r;
    logic mdc_d_r;
    logic rise;
    logic bit_in;

    msra_dev_state_t st_r, st_nxt;
    logic [5:0] ones_r, ones_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [11:0] hdr_r, hdr_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic rd_act_r, rd_act_nxt;
    logic wr_act_r, wr_act_nxt;
    logic cfg_r, cfg_nxt;
    logic out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic rdp_r, rdp_nxt;
    logic wrp_r, wrp_nxt;
    logic [4:0] phy_r, phy_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;

    logic [11:0] hdr_sh;
    logic [15:0] data_sh;
    logic [1:0] op_f;
    logic [4:0] phy_addr_field;
    logic [4:0] reg_addr_field;
    logic phy_hit;
    logic cfg_fr;
    logic rd_fr;
    logic wr_fr;

    // two-flop synchronisers; edge found on the second flop only
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_s_r <= 2'b00;
            mdio_s_r <= 2'b11;
            mdc_d_r <= 1'b0;
        end else begin
            mdc_s_r <= {mdc_s_r[0], link.mdc};
            mdio_s_r <= {mdio_s_r[0], link.mdio};
            mdc_d_r <= mdc_s_r[1];
        end
    end

    assign rise = mdc_s_r[1] & ~mdc_d_r;
    assign bit_in = mdio_s_r[1];

    assign hdr_sh = {hdr_r[10:0], bit_in};
    assign data_sh = {sh_r[14:0], bit_in};
    assign op_f = hdr_sh[11:10];
    assign phy_addr_field = hdr_sh[9:5];
    assign reg_addr_field = hdr_sh[4:0];

    // standard frames reach only the eight phy registers
    assign phy_hit = (reg_addr_field <= `MSRA_REG_STD_LAST) ||
                     (reg_addr_field == `MSRA_REG_CUST_A) ||
                     (reg_addr_field == `MSRA_REG_CUST_B);
    assign cfg_fr = (op_f == `MSRA_OP_CFG);
    // bit3 of the phy address plays no part in the decode
    assign rd_fr = (cfg_fr && phy_addr_field[4]) ||
                   (op_f == `MSRA_OP_RD && phy_hit);
    assign wr_fr = (cfg_fr && !phy_addr_field[4]) ||
                   (op_f == `MSRA_OP_WR && phy_hit);

    always_comb begin
        st_nxt = st_r;
        ones_nxt = ones_r;
        cnt_nxt = cnt_r;
        hdr_nxt = hdr_r;
        sh_nxt = sh_r;
        rd_act_nxt = rd_act_r;
        wr_act_nxt = wr_act_r;
        cfg_nxt = cfg_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        rdp_nxt = 1'b0;
        wrp_nxt = 1'b0;
        phy_nxt = phy_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        if (rise) begin
            unique case (st_r)
                MSRA_DS_PRE: begin
                    if (bit_in) begin
                        if (ones_r != PRE_CNT) begin
                            ones_nxt = ones_r + 6'h01;
                        end
                    end else if (ones_r == PRE_CNT) begin
                        st_nxt = MSRA_DS_START;
                    end else begin
                        ones_nxt = 6'h00;
                    end
                end
                MSRA_DS_START: begin
                    ones_nxt = 6'h00;
                    cnt_nxt = 4'h0;
                    if (bit_in) begin
                        st_nxt = MSRA_DS_HDR;
                    end else begin
                        st_nxt = MSRA_DS_PRE;
                    end
                end
                MSRA_DS_HDR: begin
                    hdr_nxt = hdr_sh;
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == HDR_LAST) begin
                        cnt_nxt = 4'h0;
                        st_nxt = MSRA_DS_TA;
                        cfg_nxt = cfg_fr;
                        phy_nxt = phy_addr_field;
                        if (cfg_fr) begin
                            addr_nxt = {phy_addr_field[2:0], reg_addr_field};
                        end else begin
                            addr_nxt = {3'b000, reg_addr_field};
                        end
                        rd_act_nxt = rd_fr;
                        wr_act_nxt = wr_fr;
                        rdp_nxt = rd_fr;
                    end
                end
                MSRA_DS_TA: begin
                    sh_nxt = data_sh;
                    if (cnt_r == 4'h0) begin
                        cnt_nxt = 4'h1;
                        if (rd_act_r) begin
                            // host has released the line; answer with zero
                            oe_nxt = 1'b1;
                            out_nxt = 1'b0;
                            if (cfg_r) begin
                                sh_nxt = {8'h00, acc_rdata_i[7:0]};
                            end else begin
                                sh_nxt = acc_rdata_i;
                            end
                        end
                    end else begin
                        cnt_nxt = 4'h0;
                        st_nxt = MSRA_DS_DATA;
                        if (rd_act_r) begin
                            out_nxt = sh_r[15];
                        end
                    end
                end
                MSRA_DS_DATA: begin
                    sh_nxt = data_sh;
                    cnt_nxt = cnt_r + 4'h1;
                    if (rd_act_r) begin
                        out_nxt = sh_r[15];
                    end
                    if (cnt_r == DATA_LAST) begin
                        cnt_nxt = 4'h0;
                        st_nxt = MSRA_DS_PRE;
                        ones_nxt = 6'h00;
                        oe_nxt = 1'b0;
                        out_nxt = 1'b0;
                        rd_act_nxt = 1'b0;
                        wr_act_nxt = 1'b0;
                        wrp_nxt = wr_act_r;
                        if (wr_act_r) begin
                            if (cfg_r) begin
                                wdata_nxt = {8'h00, data_sh[7:0]};
                            end else begin
                                wdata_nxt = data_sh;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= MSRA_DS_PRE;
            ones_r <= 6'h00;
            cnt_r <= 4'h0;
            hdr_r <= 12'h000;
            sh_r <= 16'h0000;
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            cfg_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            rdp_r <= 1'b0;
            wrp_r <= 1'b0;
            phy_r <= 5'h00;
            addr_r <= 8'h00;
            wdata_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            ones_r <= ones_nxt;
            cnt_r <= cnt_nxt;
            hdr_r <= hdr_nxt;
            sh_r <= sh_nxt;
            rd_act_r <= rd_act_nxt;
            wr_act_r <= wr_act_nxt;
            cfg_r <= cfg_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rdp_r <= rdp_nxt;
            wrp_r <= wrp_nxt;
            phy_r <= phy_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // config space is separate from the phy registers, reached with acc_cfg_o set
    assign acc_rd_o = rdp_r;
    assign acc_wr_o = wrp_r;
    assign acc_cfg_o = cfg_r;
    assign acc_phy_o = phy_r;
    assign acc_addr_o = addr_r;
    assign acc_wdata_o = wdata_r;
    assign link.dev_mdio_o = out_r;
    assign link.dev_mdio_oe = oe_r;
endmodule : msra_dev

// ===== msra_regs.svh
`ifndef MSRA_REGS_SVH
`define MSRA_REGS_SVH

`define MSRA_CLK_HZ 100000000
`define MSRA_MDC_MAX_HZ 5000000
`define MSRA_MDC_HALF ((`MSRA_CLK_HZ + 2 * `MSRA_MDC_MAX_HZ - 1) / (2 * `MSRA_MDC_MAX_HZ))
`define MSRA_PRE_BITS 32
`define MSRA_HDR_BITS 12
`define MSRA_DATA_BITS 16
`define MSRA_OP_RD 2'b10
`define MSRA_OP_WR 2'b01
`define MSRA_OP_CFG 2'b00
`define MSRA_TA_WR 2'b10
`define MSRA_START 2'b01
`define MSRA_REG_STD_LAST 5'h05
`define MSRA_REG_CUST_A 5'h1D
`define MSRA_REG_CUST_B 5'h1F
`define MSRA_CFG_LAST 8'hC6
`endif

// ===== msra_pkg.sv
package msra_pkg;
    typedef enum logic [1:0] {
        MSRA_STD_RD,
        MSRA_STD_WR,
        MSRA_CFG_RD,
        MSRA_CFG_WR
    } msra_op_t;

    typedef enum logic [2:0] {
        MSRA_DS_PRE,
        MSRA_DS_START,
        MSRA_DS_HDR,
        MSRA_DS_TA,
        MSRA_DS_DATA
    } msra_dev_state_t;

    typedef enum logic {
        MSRA_HS_IDLE,
        MSRA_HS_RUN
    } msra_host_state_t;
endpackage : msra_pkg

// ===== msra_if.sv
`timescale 1ns/1ps
interface msra_if;
    logic mdc;
    logic host_mdio_o;
    logic host_mdio_oe;
    logic dev_mdio_o;
    logic dev_mdio_oe;
    logic mdio;

    // pulled-up shared line: any enabled driver at zero pulls it low
    assign mdio = (~host_mdio_oe | host_mdio_o) & (~dev_mdio_oe | dev_mdio_o);

    modport dev (
        input mdc,
        input mdio,
        output dev_mdio_o,
        output dev_mdio_oe
    );

    modport host (
        output mdc,
        output host_mdio_o,
        output host_mdio_oe,
        input mdio
    );
endinterface : msra_if

// ===== msra_host.sv
`timescale 1ns/1ps
`include "msra_regs.svh"
module msra_host #(
    parameter int MDC_HALF = `MSRA_MDC_HALF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // management link
    msra_if.host link,
    // command side
    input wire logic req_i,
    input wire msra_pkg::msra_op_t op_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [15:0] rdata_o
);
    import msra_pkg::*;

    localparam logic [7:0] DIV_LAST = 8'(MDC_HALF - 1);
    localparam logic [5:0] IDX_LAST = 6'h3F;
    localparam logic [5:0] IDX_TA = 6'(`MSRA_PRE_BITS + 2 + `MSRA_HDR_BITS);
    localparam logic [5:0] IDX_DATA = IDX_TA + 6'h02;

    logic [1:0] mdio_s_r;
    msra_host_state_t st_r, st_nxt;
    logic [7:0] div_r, div_nxt;
    logic mdc_r, mdc_nxt;
    logic [5:0] idx_r, idx_nxt;
    logic [31:0] tail_r, tail_nxt;
    logic rd_r, rd_nxt;
    logic out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic [15:0] rsh_r, rsh_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [5:0] nidx;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdio_s_r <= 2'b11;
        end else begin
            mdio_s_r <= {mdio_s_r[0], link.mdio};
        end
    end

    assign nidx = idx_r + 6'h01;

    always_comb begin
        st_nxt = st_r;
        div_nxt = div_r;
        mdc_nxt = mdc_r;
        idx_nxt = idx_r;
        tail_nxt = tail_r;
        rd_nxt = rd_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        rsh_nxt = rsh_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        unique case (st_r)
            MSRA_HS_IDLE: begin
                if (req_i) begin
                    st_nxt = MSRA_HS_RUN;
                    busy_nxt = 1'b1;
                    div_nxt = 8'h00;
                    mdc_nxt = 1'b0;
                    idx_nxt = 6'h00;
                    out_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    rd_nxt = (op_i == MSRA_STD_RD) || (op_i == MSRA_CFG_RD);
                    unique case (op_i)
                        MSRA_STD_RD: begin
                            tail_nxt = {`MSRA_START, `MSRA_OP_RD, phy_addr_i, reg_addr_i,
                                        2'b00, 16'h0000};
                        end
                        MSRA_STD_WR: begin
                            tail_nxt = {`MSRA_START, `MSRA_OP_WR, phy_addr_i, reg_addr_i,
                                        `MSRA_TA_WR, wdata_i};
                        end
                        // phy bit3 goes out as given; the far end must not care
                        MSRA_CFG_RD: begin
                            tail_nxt = {`MSRA_START, `MSRA_OP_CFG, 1'b1, phy_addr_i[3:0],
                                        reg_addr_i, 2'b00, 16'h0000};
                        end
                        MSRA_CFG_WR: begin
                            tail_nxt = {`MSRA_START, `MSRA_OP_CFG, 1'b0, phy_addr_i[3:0],
                                        reg_addr_i, `MSRA_TA_WR, wdata_i};
                        end
                    endcase
                end
            end
            MSRA_HS_RUN: begin
                div_nxt = div_r + 8'h01;
                if (div_r == DIV_LAST) begin
                    div_nxt = 8'h00;
                    mdc_nxt = ~mdc_r;
                    if (!mdc_r) begin
                        // rising edge: take the device's bit
                        if (rd_r && idx_r >= IDX_DATA) begin
                            rsh_nxt = {rsh_r[14:0], mdio_s_r[1]};
                        end
                    end else if (idx_r == IDX_LAST) begin
                        st_nxt = MSRA_HS_IDLE;
                        oe_nxt = 1'b0;
                        out_nxt = 1'b0;
                        busy_nxt = 1'b0;
                        done_nxt = 1'b1;
                        rdata_nxt = rd_r ? rsh_r : 16'h0000;
                    end else begin
                        // falling edge: present the next bit
                        idx_nxt = nidx;
                        out_nxt = nidx[5] ? tail_r[~nidx[4:0]] : 1'b1;
                        oe_nxt = !(rd_r && nidx >= IDX_TA);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= MSRA_HS_IDLE;
            div_r <= 8'h00;
            mdc_r <= 1'b0;
            idx_r <= 6'h00;
            tail_r <= 32'h0000_0000;
            rd_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            rsh_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            mdc_r <= mdc_nxt;
            idx_r <= idx_nxt;
            tail_r <= tail_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rsh_r <= rsh_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign link.mdc = mdc_r;
    assign link.host_mdio_o = out_r;
    assign link.host_mdio_oe = oe_r;
    assign busy_o = busy_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
endmodule : msra_host

// ===== msra_link_properties.sv
`timescale 1ns/1ps
module msra_link_properties (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // link signals
    input wire logic mdc,
    input wire logic host_mdio_o,
    input wire logic host_mdio_oe,
    input wire logic dev_mdio_o,
    input wire logic dev_mdio_oe,
    input wire logic mdio
);
    logic mdc_q_r;
    logic oe_q_r;
    logic rise;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic cfgrd_r;
    logic cfgrd_nxt;

    // bit index within the frame, counted in clock rises since the host took the line
    always_comb begin
        rise = mdc & ~mdc_q_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        cfgrd_nxt = cfgrd_r;
        if (host_mdio_oe && !oe_q_r) begin
            cnt_nxt = 7'h00;
        end else if (rise && cnt_r != 7'h7F) begin
            cnt_nxt = cnt_r + 7'h01;
        end
        if (rise) begin
            sh_nxt = {sh_r[1:0], mdio};
        end
        // op bits and phy bit4 sit in sh_r when bit 37 is sampled
        if (rise && cnt_r == 7'h25) begin
            cfgrd_nxt = (sh_r == 3'h1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_q_r <= 1'b0;
            oe_q_r <= 1'b0;
            cnt_r <= 7'h00;
            sh_r <= 3'h0;
            cfgrd_r <= 1'b0;
        end else begin
            mdc_q_r <= mdc;
            oe_q_r <= host_mdio_oe;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            cfgrd_r <= cfgrd_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    no_contention_a: assert property (!(host_mdio_oe && dev_mdio_oe))
        else $error("host and device drive the data line together");
    mdc_high_a: assert property ($rose(mdc) |=> mdc [*8])
        else $error("management clock high phase too short");
    mdc_low_a: assert property ($fell(mdc) |=> !mdc [*8])
        else $error("management clock low phase too short");
    dev_turn_zero_a: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
        else $error("device did not answer turnaround with zero");
    dev_after_rise_a: assert property (dev_mdio_oe && $changed(dev_mdio_o) |-> mdc)
        else $error("device changed data outside clock high phase");
    host_on_fall_a: assert property (host_mdio_oe && $changed(host_mdio_o) |-> !mdc)
        else $error("host changed data while clock high");
    preamble_a: assert property (rise && cnt_r < 7'h20 |-> mdio)
        else $error("preamble bit not one");
    start_a: assert property (rise && (cnt_r == 7'h20 || cnt_r == 7'h21)
        |-> mdio == cnt_r[0])
        else $error("start pattern wrong");
    ta_a: assert property (rise && (cnt_r == 7'h2E || cnt_r == 7'h2F)
        |-> mdio == !cnt_r[0] || !(host_mdio_oe || dev_mdio_oe))
        else $error("turnaround bits wrong");
    cfg_upper_a: assert property (rise && cfgrd_r && cnt_r[6:3] == 4'h6
        |-> !mdio)
        else $error("config read upper byte not zero");
    frame_end_a: assert property (rise && cnt_r == 7'h3F
        |-> ##[1:16] !(host_mdio_oe || dev_mdio_oe))
        else $error("line not released after frame");
endmodule : msra_link_properties

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import msra_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_i = 1'b0;
    msra_op_t op_i = MSRA_STD_RD;
    logic [4:0] phy_addr_i = 5'h00;
    logic [4:0] reg_addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic busy_o;
    logic done_o;
    logic [15:0] rdata_o;
    logic acc_rd_o;
    logic acc_wr_o;
    logic acc_cfg_o;
    logic [4:0] acc_phy_o;
    logic [7:0] acc_addr_o;
    logic [15:0] acc_wdata_o;
    logic [15:0] acc_rdata_i = 16'h0000;
    logic [7:0] cfg_mem [0:255];
    logic [15:0] std_mem [0:31];
    logic [63:0] wire_r = 64'h0;
    logic [29:0] wr_cap = 30'h0;
    logic [7:0] a;
    logic [4:0] s;
    logic mdc_q = 1'b0;
    logic [7:0] ca [3] = '{8'h00, 8'h5A, 8'hC6};
    logic [4:0] sr [4] = '{5'h00, 5'h05, 5'h1D, 5'h1F};
    int n_fail = 0;
    int num_checks = 0;
    int n_rd = 0;
    int cycles = 0;
    int k;

    always #5 clk_sys_i = ~clk_sys_i;

    msra_if link ();

    msra_host #(.MDC_HALF(10)) msra_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .link(link.host), .req_i(req_i), .op_i(op_i), .phy_addr_i(phy_addr_i),
        .reg_addr_i(reg_addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o));
    msra_dev #(.PRE_BITS(32)) msra_dev_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .link(link.dev), .acc_rd_o(acc_rd_o), .acc_wr_o(acc_wr_o), .acc_cfg_o(acc_cfg_o),
        .acc_phy_o(acc_phy_o), .acc_addr_o(acc_addr_o), .acc_wdata_o(acc_wdata_o),
        .acc_rdata_i(acc_rdata_i));
    msra_link_properties msra_link_properties_i (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .mdc(link.mdc), .host_mdio_o(link.host_mdio_o),
        .host_mdio_oe(link.host_mdio_oe), .dev_mdio_o(link.dev_mdio_o),
        .dev_mdio_oe(link.dev_mdio_oe), .mdio(link.mdio));

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // register file behind the device, plus a sniffer of the wire bits
    always @(posedge clk_sys_i) begin
        mdc_q <= link.mdc;
        if (link.mdc && !mdc_q) begin
            wire_r <= {wire_r[62:0], link.mdio};
        end
        if (acc_rd_o === 1'b1) begin
            n_rd <= n_rd + 1;
            // junk upper byte: the device must not pass it on for config reads
            acc_rdata_i <= acc_cfg_o ? {8'hA5, cfg_mem[acc_addr_o]} : std_mem[acc_addr_o[4:0]];
        end
        if (acc_wr_o === 1'b1) begin
            wr_cap <= {acc_cfg_o, acc_phy_o, acc_addr_o, acc_wdata_o};
            if (acc_cfg_o) begin
                cfg_mem[acc_addr_o] <= acc_wdata_o[7:0];
            end else begin
                std_mem[acc_addr_o[4:0]] <= acc_wdata_o;
            end
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            $display("mismatch run_length expected 40000 seen %0d", cycles);
            conclude();
        end
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic xfer(input msra_op_t op, input logic [4:0] phy, input logic [4:0] rg,
        input logic [15:0] wd, input logic [15:0] exp_rd);
        logic rd;
        logic [1:0] opc;
        logic [1:0] ta;
        logic [4:0] pw;
        int n;
        logic [63:0] fr;
        rd = (op == MSRA_STD_RD) || (op == MSRA_CFG_RD);
        opc = (op == MSRA_STD_RD) ? 2'h2 : (op == MSRA_STD_WR) ? 2'h1 : 2'h0;
        pw = phy;
        if (op == MSRA_CFG_RD || op == MSRA_CFG_WR) begin
            pw[4] = (op == MSRA_CFG_RD);
        end
        // an unanswered read leaves the line pulled up through turnaround
        ta = (rd && exp_rd === 16'hFFFF) ? 2'h3 : 2'h2;
        req_i <= 1'b1;
        op_i <= op;
        phy_addr_i <= phy;
        reg_addr_i <= rg;
        wdata_i <= wd;
        @(posedge clk_sys_i);
        req_i <= 1'b0;
        @(posedge clk_sys_i);
        check("busy_o", 64'h1, {63'h0, busy_o});
        n = 0;
        while (done_o !== 1'b1 && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        check("done_o", 64'h1, {63'h0, done_o});
        check("busy_o", 64'h0, {63'h0, busy_o});
        fr = {32'hFFFF_FFFF, 2'h1, opc, pw, rg, ta, rd ? exp_rd : wd};
        check("frame", fr, wire_r);
        if (rd) begin
            check("rdata_o", {48'h0, exp_rd}, {48'h0, rdata_o});
        end
    endtask : xfer

    initial begin
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        // phy bit3 is set in every config frame and must be ignored
        for (int i = 0; i < 3; i++) begin
            a = ca[i];
            xfer(MSRA_CFG_WR, {2'h1, a[7:5]}, a[4:0], {8'hFF, ~a}, 16'h0);
            check("cfg_write", {1'b1, 2'h1, a[7:5], a, 8'h00, ~a}, wr_cap);
            xfer(MSRA_CFG_RD, {2'h1, a[7:5]}, a[4:0], 16'h0, {8'h00, ~a});
        end
        $display("test config access done");
        for (int i = 0; i < 4; i++) begin
            s = sr[i];
            xfer(MSRA_STD_WR, 5'h11, s, {3'h5, s, 8'h3C}, 16'h0);
            check("std_write", {1'b0, 5'h11, 3'h0, s, 3'h5, s, 8'h3C}, wr_cap);
            xfer(MSRA_STD_RD, 5'h11, s, 16'h0, {3'h5, s, 8'h3C});
        end
        $display("test standard access done");
        k = n_rd;
        xfer(MSRA_STD_RD, 5'h02, 5'h06, 16'h0, 16'hFFFF);
        check("read_strobes", k, n_rd);
        xfer(MSRA_STD_WR, 5'h02, 5'h1E, 16'h1234, 16'h0);
        check("unmapped_write", {1'b0, 5'h11, 8'h1F, 3'h5, 5'h1F, 8'h3C}, wr_cap);
        $display("test unmapped standard register done");
        conclude();
    end
endmodule : tb
